// ### rtl/battery_preservation_monitor.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Supply guard configuration, undervoltage cut-off and
//          battery-saving overdrive clamp selection.
// Assumes: Register port strobes are one-cycle pulses; supply inputs are
//          synchronous to sys_clk.
// Notes: The clamp is latched once per effect at effect_start.
// What this block does
// - Level select bits 7-6 off at 0, first level only at 1.
// - Level select 2 enables first and second levels together.
// - Bits 2-0 pick 2.5 V to 3.2 V in 0.1 V steps, reset to code 0.
// - Supply under the threshold cuts the output stage and enters standby.
// - First level below threshold A uses limit one; A resets to 146.
// - Second level below threshold B (bits 7-0) uses limit two.
// - Supply is sampled once at effect start; clamp holds during the effect.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module battery_preservation_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [11:0] supply_mv,
   input wire logic [7:0] supply_code,
   input wire supply_guard_pkg::limit_set_s limits,
   input wire logic effect_start,
   input wire logic effect_done,
   output logic [7:0] od_clamp,
   output logic [1:0] clamp_level,
   output logic effect_playing,
   output logic stage_enable,
   output logic standby
);

   typedef struct packed {
      supply_guard_pkg::guard_cfg_s cfg;
      logic [7:0] thr_a;
      logic [7:0] thr_b;
      logic [7:0] rdata;
      logic [7:0] clamp;
      supply_guard_pkg::clamp_level_e level;
      logic playing;
      logic stage_en;
      logic standby;
   } monitor_state_s;

   monitor_state_s s;
   monitor_state_s next_s;
   logic uv_low;
   logic sample;

   ///////////////////////////////////////////////////////////////////////////
   undervoltage_compare u_uv (
      .undervoltage_threshold_code(s.cfg.undervoltage_threshold_code),
      .supply_mv(supply_mv),
      .below(uv_low)
   );

   assign sample = effect_start && !uv_low;

   ///////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      if (reg_wr) begin
         unique case (reg_addr)
            supply_guard_pkg::SUPPLY_GUARD_CONFIG_OFS: begin
               next_s.cfg = supply_guard_pkg::guard_cfg_s'(reg_wdata);
            end
            supply_guard_pkg::BATTERY_SAVE_THRESHOLD_A_OFS: begin
               next_s.thr_a = reg_wdata;
            end
            supply_guard_pkg::BATTERY_SAVE_THRESHOLD_B_OFS: begin
               next_s.thr_b = reg_wdata;
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            supply_guard_pkg::SUPPLY_GUARD_CONFIG_OFS: begin
               next_s.rdata = s.cfg;
            end
            supply_guard_pkg::BATTERY_SAVE_THRESHOLD_A_OFS: begin
               next_s.rdata = s.thr_a;
            end
            supply_guard_pkg::BATTERY_SAVE_THRESHOLD_B_OFS: begin
               next_s.rdata = s.thr_b;
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end
      if (effect_done) begin
         next_s.playing = 1'b0;
      end
      // The supply code is judged only here; apart from reset, nothing else touches the clamp.
      if (sample) begin
         next_s.playing = 1'b1;
         next_s.level = supply_guard_pkg::CLAMP_FULL;
         next_s.clamp = limits.overdrive_limit_full;
         unique case (s.cfg.battery_save_level_select)
            supply_guard_pkg::SAVE_ONE: begin
               if (supply_code < s.thr_a) begin
                  next_s.level = supply_guard_pkg::CLAMP_ONE;
                  next_s.clamp = limits.overdrive_limit_one;
               end
            end
            supply_guard_pkg::SAVE_BOTH: begin
               if (supply_code < s.thr_b) begin
                  next_s.level = supply_guard_pkg::CLAMP_TWO;
                  next_s.clamp = limits.overdrive_limit_two;
               end else if (supply_code < s.thr_a) begin
                  next_s.level = supply_guard_pkg::CLAMP_ONE;
                  next_s.clamp = limits.overdrive_limit_one;
               end
            end
            default: begin
               // Off, and the undefined code 3, apply no saving.
            end
         endcase
      end
      // Undervoltage cuts the stage on the next clock edge and ends any effect.
      next_s.stage_en = !uv_low;
      next_s.standby = uv_low;
      if (uv_low) begin
         next_s.playing = 1'b0;
      end
      if (!rst_n) begin
         next_s.cfg = supply_guard_pkg::guard_cfg_s'(
            supply_guard_pkg::SUPPLY_GUARD_CONFIG_RST);
         next_s.thr_a = supply_guard_pkg::BATTERY_SAVE_THRESHOLD_A_RST;
         next_s.thr_b = supply_guard_pkg::BATTERY_SAVE_THRESHOLD_B_RST;
         next_s.rdata = 8'h00;
         next_s.clamp = supply_guard_pkg::CLAMP_RST;
         next_s.level = supply_guard_pkg::CLAMP_FULL;
         next_s.playing = 1'b0;
         next_s.stage_en = 1'b0;
         next_s.standby = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      s <= next_s;
   end

   assign reg_rdata = s.rdata;
   assign od_clamp = s.clamp;
   assign clamp_level = s.level;
   assign effect_playing = s.playing;
   assign stage_enable = s.stage_en;
   assign standby = s.standby;

   ///////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sel_one_low;
      sample && s.cfg.battery_save_level_select == supply_guard_pkg::SAVE_ONE
         && supply_code < s.thr_a;
   endsequence

   sequence sel_both_below_b;
      sample && s.cfg.battery_save_level_select == supply_guard_pkg::SAVE_BOTH
         && supply_code < s.thr_b;
   endsequence

   chk_sel_off_full: assert property (
      sample && s.cfg.battery_save_level_select == supply_guard_pkg::SAVE_OFF
      |=> clamp_level == 2'b00 && od_clamp == $past(limits.overdrive_limit_full))
      else $error("Disabled saving did not apply the full clamp.");

   chk_level_one_clamp: assert property (
      sel_one_low |=> clamp_level == 2'b01
      && od_clamp == $past(limits.overdrive_limit_one))
      else $error("First level did not apply limit one.");

   chk_both_prefer_two: assert property (
      sel_both_below_b ##0 (supply_code < s.thr_a) |=> clamp_level == 2'b10)
      else $error("Both levels below both thresholds did not pick level two.");

   chk_level_two_clamp: assert property (
      sel_both_below_b |=> od_clamp == $past(limits.overdrive_limit_two))
      else $error("Second level did not apply limit two.");

   chk_uv_decode: assert property (
      uv_low == (supply_mv < 12'(12'h9C4
         + 12'(s.cfg.undervoltage_threshold_code) * 12'h064)))
      else $error("Undervoltage threshold decode is wrong.");

   chk_uv_cutoff: assert property (
      uv_low |=> !stage_enable && standby && !effect_playing)
      else $error("Undervoltage did not cut the stage and enter standby.");

   chk_thr_reset: assert property (
      $rose(rst_n) |-> s.thr_a == 8'h92 && s.cfg.undervoltage_threshold_code == 0)
      else $error("Threshold or code reset value is wrong.");

   chk_clamp_hold: assert property (
      !sample [*2] |-> $stable(od_clamp) && $stable(clamp_level))
      else $error("Clamp changed during an effect.");

   chk_both_level_one: assert property (
      sample && s.cfg.battery_save_level_select == supply_guard_pkg::SAVE_BOTH
      && !(supply_code < s.thr_b) && supply_code < s.thr_a
      |=> clamp_level == 2'b01
      && od_clamp == $past(limits.overdrive_limit_one))
      else $error("Both levels above threshold B did not pick level one.");

   chk_stage_restore: assert property (
      !uv_low |=> stage_enable && !standby)
      else $error("Stage did not return once the supply recovered.");

   chk_thr_b_write: assert property (
      reg_wr && reg_addr == supply_guard_pkg::BATTERY_SAVE_THRESHOLD_B_OFS
      |=> s.thr_b == $past(reg_wdata))
      else $error("Threshold B write did not land.");

endmodule

// ### rtl/supply_guard_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the battery preservation monitor.
// Assumes: Register offsets address an 8-bit register space.
// Notes: Supply thresholds for undervoltage are handled in millivolts.
//////////////////////////////////////////////////////////////////////////////
package supply_guard_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int MV_W = 12;

   localparam logic [7:0] SUPPLY_GUARD_CONFIG_OFS = 8'h09;
   localparam logic [7:0] BATTERY_SAVE_THRESHOLD_A_OFS = 8'h0A;
   localparam logic [7:0] BATTERY_SAVE_THRESHOLD_B_OFS = 8'h0B;

   localparam logic [7:0] SUPPLY_GUARD_CONFIG_RST = 8'h00;
   localparam logic [7:0] BATTERY_SAVE_THRESHOLD_A_RST = 8'h92;
   localparam logic [7:0] BATTERY_SAVE_THRESHOLD_B_RST = 8'h8D;
   localparam logic [7:0] CLAMP_RST = 8'h00;

   // Undervoltage threshold is base plus code times step.
   localparam logic [11:0] UV_BASE_MV = 12'h9C4;
   localparam logic [11:0] UV_STEP_MV = 12'h064;

   typedef enum logic [1:0] {
      SAVE_OFF = 2'b00,
      SAVE_ONE = 2'b01,
      SAVE_BOTH = 2'b10,
      SAVE_UNDEF = 2'b11
   } save_select_e;

   typedef enum logic [1:0] {
      CLAMP_FULL = 2'b00,
      CLAMP_ONE = 2'b01,
      CLAMP_TWO = 2'b10
   } clamp_level_e;

   // Field layout of the supply guard configuration register.
   typedef struct packed {
      save_select_e battery_save_level_select;
      logic [2:0] reserved;
      logic [2:0] undervoltage_threshold_code;
   } guard_cfg_s;

   typedef struct packed {
      logic [7:0] overdrive_limit_full;
      logic [7:0] overdrive_limit_one;
      logic [7:0] overdrive_limit_two;
   } limit_set_s;

endpackage

// ### rtl/undervoltage_compare.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Decodes the undervoltage code and compares the supply against it.
// Assumes: Supply is presented in millivolts, synchronous to the clock.
// Notes: Purely combinational; the caller registers the result.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module undervoltage_compare (
   input wire logic [2:0] undervoltage_threshold_code,
   input wire logic [11:0] supply_mv,
   output logic below
);

   function automatic logic [11:0] threshold_mv(input logic [2:0] code);
      logic [11:0] step;
      step = 12'(code) * supply_guard_pkg::UV_STEP_MV;
      threshold_mv = 12'(supply_guard_pkg::UV_BASE_MV + step);
   endfunction

   always_comb begin
      below = supply_mv < threshold_mv(undervoltage_threshold_code);
   end

endmodule

// ### verif/battery_preservation_monitor_tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the battery preservation monitor.
// Assumes: Inputs change on the falling edge of sys_clk.
// Notes: Registers, undervoltage sweep and clamp selection per effect.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module battery_preservation_monitor_tb_top;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [11:0] supply_mv = 12'hE10;
   logic [7:0] supply_code = 8'hFF;
   supply_guard_pkg::limit_set_s limits = 24'hF0A050;
   logic effect_start = 1'b0;
   logic effect_done = 1'b0;
   logic [7:0] od_clamp;
   logic [1:0] clamp_level;
   logic effect_playing;
   logic stage_enable;
   logic standby;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   always #2 sys_clk = ~sys_clk;

   battery_preservation_monitor battery_preservation_monitor_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .supply_mv(supply_mv),
      .supply_code(supply_code), .limits(limits),
      .effect_start(effect_start), .effect_done(effect_done),
      .od_clamp(od_clamp), .clamp_level(clamp_level),
      .effect_playing(effect_playing), .stage_enable(stage_enable),
      .standby(standby));

   ///////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [11:0] seen,
                        input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // A spare cycle keeps a following strobe out of this time step.
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      check("register read", reg_rdata, exp);
      @(negedge sys_clk);
   endtask

   // Sets the level select, presents the supply code and starts an effect.
   task automatic eff(input logic [1:0] sel, input logic [7:0] code,
                      input logic [1:0] lvl, input logic [7:0] clamp);
      wr(8'h09, {sel, 6'h00});
      supply_code = code;
      effect_start = 1'b1;
      @(negedge sys_clk);
      effect_start = 1'b0;
      check("clamp level", clamp_level, lvl);
      check("clamp value", od_clamp, clamp);
      check("effect playing", effect_playing, 1'b1);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("timeout reached");
         end_sim();
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      check("stage after reset", stage_enable, 1'b1);
      rd(8'h09, 8'h00);
      rd(8'h0A, 8'h92);
      rd(8'h0B, supply_guard_pkg::BATTERY_SAVE_THRESHOLD_B_RST);
      wr(8'h0A, 8'h50);
      wr(8'h0B, 8'h30);
      wr(8'h0C, 8'h55);
      wr(8'h09, 8'hFF);
      rd(8'h0A, 8'h50);
      rd(8'h0B, 8'h30);
      rd(8'h0C, 8'h00);
      rd(8'h09, 8'hFF);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h09, {5'h00, c[2:0]});
         supply_mv = 12'h9C3 + 12'h064 * c[11:0];
         @(negedge sys_clk);
         check("stage cut", stage_enable, 1'b0);
         check("standby set", standby, 1'b1);
         supply_mv = 12'h9C4 + 12'h064 * c[11:0];
         @(negedge sys_clk);
         check("stage on", stage_enable, 1'b1);
         check("standby clear", standby, 1'b0);
      end
      supply_mv = 12'hE10;
      $display("test undervoltage done");
      eff(2'h0, 8'h10, 2'h0, 8'hF0);
      eff(2'h1, 8'h40, 2'h1, 8'hA0);
      eff(2'h1, 8'h10, 2'h1, 8'hA0);
      eff(2'h1, 8'h50, 2'h0, 8'hF0);
      eff(2'h2, 8'h40, 2'h1, 8'hA0);
      eff(2'h3, 8'h10, 2'h0, 8'hF0);
      eff(2'h2, 8'h2F, 2'h2, 8'h50);
      supply_code = 8'hFF;
      repeat (3) @(negedge sys_clk);
      check("held level", clamp_level, 2'h2);
      check("held clamp", od_clamp, 8'h50);
      effect_done = 1'b1;
      @(negedge sys_clk);
      effect_done = 1'b0;
      check("done clears", effect_playing, 1'b0);
      $display("test clamp done");
      eff(2'h2, 8'h2F, 2'h2, 8'h50);
      supply_mv = 12'h9C3;
      @(negedge sys_clk);
      check("cut mid effect", effect_playing, 1'b0);
      check("stage mid effect", stage_enable, 1'b0);
      effect_start = 1'b1;
      @(negedge sys_clk);
      effect_start = 1'b0;
      check("start refused", effect_playing, 1'b0);
      supply_mv = 12'hE10;
      @(negedge sys_clk);
      check("stage back", stage_enable, 1'b1);
      $display("test cut mid effect done");
      end_sim();
   end
endmodule
